// >>> hw/sweep_bus_if.sv
// Carrier of the instrument bus between the controller and the sweep board.
// Assumes a pull-up on every data line and on the request line, so that
// each resolved wire is the AND of whatever its drivers put on it.
`timescale 1ns/1ps
interface sweep_bus_if;
  logic [7:0] addr;
  logic read_strobe;
  logic write_strobe;
  logic poll;
  logic [7:0] host_db_out;
  logic [7:0] host_db_oe_n;
  logic [7:0] dev_db_out;
  logic [7:0] dev_db_oe_n;
  logic service_request_n_out;
  logic service_request_n_oe_n;
  logic [7:0] db;
  logic service_request_n;

  // A released driver counts as high, as the pull-up would make it.
  assign db = (host_db_oe_n | host_db_out) & (dev_db_oe_n | dev_db_out);
  assign service_request_n = service_request_n_oe_n | service_request_n_out;

  modport dev (
    input addr,
    input read_strobe,
    input write_strobe,
    input poll,
    input db,
    output dev_db_out,
    output dev_db_oe_n,
    output service_request_n_out,
    output service_request_n_oe_n
  );

  modport host (
    output addr,
    output read_strobe,
    output write_strobe,
    output poll,
    output host_db_out,
    output host_db_oe_n,
    input db,
    input service_request_n
  );
endinterface

// >>> hw/sweep_bus_pkg.sv
// Shared constants for the sweep-board service request link.
// Assumes both ends and the bus carrier are compiled after this package.
package sweep_bus_pkg;

  // Instrument bus addresses, and the acknowledge data word, that the sweep board decodes or that
  // the controller places on the bus.
  localparam logic [7:0] ADDR_TRIGGER = 8'h0f;
  localparam logic [7:0] ADDR_CONTROL = 8'h1f;
  localparam logic [7:0] ADDR_STATUS = 8'h9f;
  localparam logic [7:0] ADDR_POLL = 8'hff;
  localparam logic [7:0] ADDR_ACK = 8'h7f;
  localparam logic [7:0] ACK_SWEEP_WORD = 8'hef;

  // Bit positions on the address and data buses.
  localparam int POLL_ADDR_BIT = 7;
  localparam int STAT_REF_BIT = 0;
  localparam int STAT_LOCK_BIT = 1;
  localparam int REF_SELECT_BIT = 4;
  localparam int EOS_ENABLE_BIT = 1;
  localparam int POLL_SWEEP_BIT = 4;
  localparam int POLL_STATUS_BIT = 7;

  // Values after reset.
  localparam logic REF_SELECT_RESET = 1'b1;
  localparam logic EOS_ENABLE_RESET = 1'b0;

  // Width of the synchronised input vector of the device end.
  localparam int DEV_IN_W = 22;
  // Width of the synchronised input vector of the controller end.
  localparam int HOST_IN_W = 9;

  // Count at which each bus phase of the controller ends; a phase lasts one cycle more.
  localparam int STEP_W = 5;
  localparam logic [STEP_W-1:0] STEP_CYCLES = 5'h10;

  // Controller register offsets on AHB-Lite.
  localparam logic [7:0] OFS_CMD = 8'h00;
  localparam logic [7:0] OFS_RESULT = 8'h04;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;

  // Field positions of the controller registers.
  localparam int CMD_DATA_LSB = 0;
  localparam int CMD_ADDR_LSB = 8;
  localparam int CMD_OP_LSB = 16;
  localparam int RES_BUSY_BIT = 8;
  localparam int RES_REQ_BIT = 9;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_REQ_BIT = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [2:0] {
    OP_WRITE,
    OP_READ,
    OP_POLL,
    OP_ACK_SWEEP,
    OP_ACK_STATUS
  } host_op_t;

endpackage

// >>> hw/sweep_service_device.sv
// Sweep-board end: reference status read-back, two request sources,
// the shared service request line and the poll response.
// Assumes every bus line and every input from the reference and sweep
// circuits is asynchronous to ref_clk and is held for many clock cycles.
//
// Decided for this implementation: the AHB-Lite slave port.
`timescale 1ns/1ps
module sweep_service_device
  import sweep_bus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic internal_reference_status,
  input wire logic lock_lost,
  input wire logic sweep_end_event,
  output logic internal_reference_select,
  sweep_bus_if.dev bus
);

  logic [DEV_IN_W-1:0] raw;
  logic [DEV_IN_W-1:0] sync1;
  logic [DEV_IN_W-1:0] sync2;
  logic [DEV_IN_W-1:0] sync3;
  logic [DEV_IN_W-1:0] filt;
  logic [DEV_IN_W-1:0] filt_prev;

  logic [7:0] addr_q;
  logic [7:0] db_q;
  logic poll_q;
  logic rd_q;
  logic wr_q;
  logic live_ref;
  logic live_lock;
  logic eos_q;

  logic poll_rise;
  logic poll_fall;
  logic rd_rise;
  logic wr_fall;
  logic eos_rise;
  logic poll_window;
  logic status_read;

  logic [1:0] snapshot;
  logic mismatch;
  logic mismatch_prev;
  logic status_set;
  logic status_clr;
  logic status_pending;

  logic sweep_end_enable;
  logic sweep_set;
  logic sweep_clr;
  logic sweep_pending;
  logic any_pending;

  logic ack_sweep_armed;
  logic ack_status_armed;

  // Every outside line goes through the same three-stage filter.
  assign raw = {bus.addr, bus.db, bus.poll, bus.read_strobe,
                bus.write_strobe, internal_reference_status, lock_lost,
                sweep_end_event};

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
    end else begin
      sync1 <= raw;
      sync2 <= sync1;
      sync3 <= sync2;
    end
  end

  // A level is taken only once the second and third stage agree, which
  // rejects a single-cycle glitch at the price of one cycle of latency.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      filt <= '0;
      filt_prev <= '0;
    end else begin
      filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
      filt_prev <= filt;
    end
  end

  assign addr_q = filt[21:14];
  assign db_q = filt[13:6];
  assign poll_q = filt[5];
  assign rd_q = filt[4];
  assign wr_q = filt[3];
  assign live_ref = filt[2];
  assign live_lock = filt[1];
  assign eos_q = filt[0];

  // Poll edges arm and fire the acknowledge; the poll window uses its level.
  assign poll_rise = poll_q & ~filt_prev[5];
  assign poll_fall = ~poll_q & filt_prev[5];
  assign rd_rise = rd_q & ~filt_prev[4];
  assign wr_fall = ~wr_q & filt_prev[3];
  assign eos_rise = eos_q & ~filt_prev[0];

  assign poll_window = poll_q & addr_q[POLL_ADDR_BIT];
  // Register decode is held off while a poll is in progress.
  assign status_read = ~poll_q & rd_q & (addr_q == ADDR_STATUS);

  // Control writes take effect on the trailing edge of the strobe, when
  // address and data have had the whole strobe to settle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      internal_reference_select <= REF_SELECT_RESET;
      sweep_end_enable <= EOS_ENABLE_RESET;
    end else if (wr_fall && !poll_q) begin
      if (addr_q == ADDR_CONTROL) begin
        internal_reference_select <= db_q[REF_SELECT_BIT];
      end
      if (addr_q == ADDR_TRIGGER) begin
        sweep_end_enable <= db_q[EOS_ENABLE_BIT];
      end
    end
  end

  // Snapshot of the reference pair, refreshed at the start of each status read.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      snapshot <= 2'h0;
    end else if (rd_rise && !poll_q && addr_q == ADDR_STATUS) begin
      snapshot <= {live_lock, live_ref};
    end
  end

  // A change that happens during the read itself makes a fresh mismatch
  // at once, so no status change slips between read and snapshot.
  assign mismatch = (snapshot != {live_lock, live_ref});

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mismatch_prev <= 1'b0;
    end else begin
      mismatch_prev <= mismatch;
    end
  end

  assign status_set = mismatch & ~mismatch_prev;
  assign sweep_set = eos_rise & sweep_end_enable;

  // A poll pulse with bit 7 of the address low is an acknowledge; the
  // word on the data bus at the rising edge says which flag it is for.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_sweep_armed <= 1'b0;
      ack_status_armed <= 1'b0;
    end else if (poll_rise && !addr_q[POLL_ADDR_BIT]) begin
      ack_sweep_armed <= (db_q == ACK_SWEEP_WORD);
      ack_status_armed <= (db_q != ACK_SWEEP_WORD);
    end else if (poll_fall) begin
      ack_sweep_armed <= 1'b0;
      ack_status_armed <= 1'b0;
    end
  end

  assign sweep_clr = poll_fall & ack_sweep_armed;
  assign status_clr = poll_fall & ack_status_armed;

  // In both flags a new event wins over an acknowledge in the same cycle.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sweep_pending <= 1'b0;
    end else if (sweep_set) begin
      sweep_pending <= 1'b1;
    end else if (sweep_clr) begin
      sweep_pending <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      status_pending <= 1'b0;
    end else if (status_set) begin
      status_pending <= 1'b1;
    end else if (status_clr) begin
      status_pending <= 1'b0;
    end
  end

  assign any_pending = sweep_pending | status_pending;

  // The request line is open drain: pulled low or released, never high.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.service_request_n_out <= 1'b1;
      bus.service_request_n_oe_n <= 1'b1;
    end else begin
      bus.service_request_n_out <= ~any_pending;
      bus.service_request_n_oe_n <= ~any_pending;
    end
  end

  // Data bus drive: poll answer in the poll window, status on a read of
  // the status address, and released otherwise.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.dev_db_out <= 8'hff;
      bus.dev_db_oe_n <= 8'hff;
    end else begin
      bus.dev_db_out <= 8'hff;
      bus.dev_db_oe_n <= 8'hff;
      if (poll_window) begin
        if (sweep_pending) begin
          bus.dev_db_out[POLL_SWEEP_BIT] <= 1'b0;
          bus.dev_db_oe_n[POLL_SWEEP_BIT] <= 1'b0;
        end
        if (status_pending) begin
          bus.dev_db_out[POLL_STATUS_BIT] <= 1'b0;
          bus.dev_db_oe_n[POLL_STATUS_BIT] <= 1'b0;
        end
      end else if (status_read) begin
        bus.dev_db_out[STAT_REF_BIT] <= live_ref;
        bus.dev_db_out[STAT_LOCK_BIT] <= live_lock;
        bus.dev_db_oe_n[STAT_REF_BIT] <= 1'b0;
        bus.dev_db_oe_n[STAT_LOCK_BIT] <= 1'b0;
      end
    end
  end

endmodule

// >>> hw/sweep_service_host.sv
// Controller end: an AHB-Lite register slave whose commands run single
// bus cycles, polls and acknowledges on the instrument bus.
// Assumes one AHB-Lite master and the bus lines of the sweep board
// arriving asynchronously to ref_clk.
`timescale 1ns/1ps
module sweep_service_host
  import sweep_bus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic irq,
  sweep_bus_if.host bus
);

  typedef enum logic [1:0] {H_IDLE, H_SETUP, H_STROBE, H_RELEASE} host_state_t;

  host_state_t state;
  host_op_t op;
  logic [7:0] cmd_addr;
  logic [7:0] cmd_data;
  logic [STEP_W-1:0] step_cnt;
  logic step_done;
  logic [7:0] result;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_set;
  logic [HOST_IN_W-1:0] sync1;
  logic [HOST_IN_W-1:0] sync2;
  logic [HOST_IN_W-1:0] sync3;
  logic [HOST_IN_W-1:0] filt;
  logic req_prev;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic cmd_write;

  // Inputs from the sweep board pass the same three-stage filter.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      filt <= '0;
    end else begin
      sync1 <= {~bus.service_request_n, bus.db};
      sync2 <= sync1;
      sync3 <= sync2;
      filt <= (sync2 & sync3) | (filt & (sync2 ^ sync3));
    end
  end

  // Zero-wait slave: read data are loaded at the address phase edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend <= 1'b0;
      wr_addr <= 8'h0;
    end else begin
      wr_pend <= hsel & htrans[1] & hready & hwrite;
      wr_addr <= haddr[7:0];
      hrdata <= 32'h0;
      if (hsel && htrans[1] && hready && !hwrite) begin
        unique case (haddr[7:0])
          OFS_RESULT: hrdata <= {22'h0, filt[8], state != H_IDLE, result};
          OFS_IRQ_STATUS: hrdata <= {30'h0, irq_status};
          OFS_IRQ_MASK: hrdata <= {30'h0, irq_mask};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end

  // A command written while one is running is dropped.
  assign cmd_write = wr_pend && wr_addr == OFS_CMD && state == H_IDLE;
  assign step_done = (step_cnt == STEP_CYCLES);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= H_IDLE;
      step_cnt <= '0;
      op <= OP_WRITE;
      cmd_addr <= 8'h0;
      cmd_data <= 8'h0;
    end else begin
      step_cnt <= step_done ? '0 : step_cnt + 1'b1;
      unique case (state)
        H_IDLE: begin
          step_cnt <= '0;
          if (cmd_write) begin
            op <= host_op_t'(hwdata[CMD_OP_LSB +: 3]);
            cmd_addr <= hwdata[CMD_ADDR_LSB +: 8];
            cmd_data <= hwdata[CMD_DATA_LSB +: 8];
            state <= H_SETUP;
          end
        end
        H_SETUP: if (step_done) state <= H_STROBE;
        H_STROBE: if (step_done) state <= H_RELEASE;
        H_RELEASE: if (step_done) state <= H_IDLE;
      endcase
    end
  end

  // Bus drive follows the phase; address and data stay on through the
  // release phase so the board sees them at the trailing strobe edge.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      bus.addr <= 8'h0;
      bus.read_strobe <= 1'b0;
      bus.write_strobe <= 1'b0;
      bus.poll <= 1'b0;
      bus.host_db_out <= 8'hff;
      bus.host_db_oe_n <= 8'hff;
    end else begin
      bus.read_strobe <= state == H_STROBE && op == OP_READ;
      bus.write_strobe <= state == H_STROBE && op == OP_WRITE;
      bus.poll <= state == H_STROBE && op != OP_READ && op != OP_WRITE;
      bus.host_db_out <= 8'hff;
      bus.host_db_oe_n <= 8'hff;
      if (state != H_IDLE) begin
        unique case (op)
          OP_POLL: bus.addr <= ADDR_POLL;
          OP_ACK_SWEEP, OP_ACK_STATUS: bus.addr <= ADDR_ACK;
          default: bus.addr <= cmd_addr;
        endcase
        if (op == OP_WRITE) begin
          bus.host_db_out <= cmd_data;
          bus.host_db_oe_n <= 8'h00;
        end else if (op == OP_ACK_SWEEP) begin
          bus.host_db_out <= ACK_SWEEP_WORD;
          bus.host_db_oe_n <= 8'h00;
        end
      end
    end
  end

  // Data are taken at the end of the strobe phase.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      result <= 8'h0;
    end else if (state == H_STROBE && step_done &&
                 (op == OP_READ || op == OP_POLL)) begin
      result <= filt[7:0];
    end
  end

  assign irq_set[IRQ_DONE_BIT] = state == H_RELEASE && step_done;
  assign irq_set[IRQ_REQ_BIT] = filt[8] & ~req_prev;

  // Sticky status, write one to clear; a new event wins over the clear.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      req_prev <= 1'b0;
      irq_status <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
    end else begin
      req_prev <= filt[8];
      if (wr_pend && wr_addr == OFS_IRQ_STATUS) begin
        irq_status <= (irq_status & ~hwdata[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_status <= irq_status | irq_set;
      end
      if (wr_pend && wr_addr == OFS_IRQ_MASK) begin
        irq_mask <= hwdata[IRQ_W-1:0];
      end
      irq <= |(irq_status & irq_mask);
    end
  end

endmodule

// >>> testbench/sweep_board_service_request_tb.sv
// Testbench of both service-request ends joined on one instrument bus.
// Assumes the host end is the only AHB-Lite slave and the bench the master.
`timescale 1ns/1ps
module sweep_board_service_request_tb
  import sweep_bus_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic ref_status = 1'b0;
  logic lock_lost = 1'b0;
  logic sweep_end_event = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic irq;
  logic internal_reference_select;
  int err_count = 0;
  int checked = 0;

  sweep_bus_if bus ();
  sweep_service_device i_sweep_service_device (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .internal_reference_status(ref_status), .lock_lost(lock_lost),
    .sweep_end_event(sweep_end_event),
    .internal_reference_select(internal_reference_select), .bus(bus));
  sweep_service_host i_sweep_service_host (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .irq(irq), .bus(bus));
  sweep_bus_assertions i_sweep_bus_assertions (
    .ref_clk(ref_clk), .rst_n(rst_n), .addr(bus.addr),
    .read_strobe(bus.read_strobe), .write_strobe(bus.write_strobe),
    .poll(bus.poll), .dev_db_out(bus.dev_db_out),
    .dev_db_oe_n(bus.dev_db_oe_n),
    .service_request_n_out(bus.service_request_n_out),
    .service_request_n_oe_n(bus.service_request_n_oe_n),
    .service_request_n(bus.service_request_n));

  always #50 ref_clk = ~ref_clk;

  task automatic test_done;
    $display("checked=%0d err_count=%0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // One single word transfer; entered and left just after a rising edge.
  task automatic bus_cycle(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    int n;
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {24'h0, a};
    hwrite <= wr;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (n >= 100) begin
      err_count++;
      test_done();
    end
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 200);
    q = hrdata;
    if (n >= 200) begin
      err_count++;
      test_done();
    end
  endtask

  // Done is cleared first so a stale flag cannot end the wait early.
  task automatic run_cmd(input host_op_t op, input logic [7:0] a,
      input logic [7:0] d, output logic [31:0] q);
    int n;
    bus_cycle(1'b1, OFS_IRQ_STATUS, 32'h1, q);
    bus_cycle(1'b1, OFS_CMD, {13'h0, op, a, d}, q);
    n = 0;
    q = 32'h0;
    while (q[IRQ_DONE_BIT] !== 1'b1 && n < 200) begin
      bus_cycle(1'b0, OFS_IRQ_STATUS, 32'h0, q);
      n++;
    end
    if (n >= 200) begin
      err_count++;
      test_done();
    end
    bus_cycle(1'b0, OFS_RESULT, 32'h0, q);
  endtask

  task automatic req_is(input logic e);
    check({31'h0, bus.service_request_n}, {31'h0, e});
  endtask

  task automatic wait_req(input logic e);
    int n;
    n = 0;
    while (bus.service_request_n !== e && n < 60) begin
      @(posedge ref_clk);
      n++;
    end
    req_is(e);
    if (n >= 60) test_done();
  endtask

  task automatic poll_is(input logic [7:0] e);
    logic [31:0] q;
    run_cmd(OP_POLL, ADDR_POLL, 8'hff, q);
    check({24'h0, q[7:0]}, {24'h0, e});
  endtask

  task automatic pulse_end;
    sweep_end_event <= 1'b1;
    repeat (6) @(posedge ref_clk);
    sweep_end_event <= 1'b0;
    repeat (20) @(posedge ref_clk);
  endtask

  task automatic t_reset;
    logic [31:0] q;
    check({31'h0, internal_reference_select}, 32'h1);
    req_is(1'b1);
    bus_cycle(1'b0, OFS_IRQ_MASK, 32'h0, q);
    check(q, 32'h0);
    bus_cycle(1'b0, 8'h10, 32'h0, q);
    check(q, 32'h0);
    check({30'h0, hresp, hreadyout}, 32'h1);
  endtask

  task automatic t_ref_select;
    logic [31:0] q;
    run_cmd(OP_WRITE, ADDR_CONTROL, 8'h00, q);
    check({31'h0, internal_reference_select}, 32'h0);
    run_cmd(OP_WRITE, 8'h2f, 8'hff, q);
    check({31'h0, internal_reference_select}, 32'h0);
    run_cmd(OP_WRITE, ADDR_CONTROL, 8'h10, q);
    check({31'h0, internal_reference_select}, 32'h1);
  endtask

  task automatic status_round(input logic r, input logic l);
    logic [31:0] q;
    ref_status <= r;
    lock_lost <= l;
    wait_req(1'b0);
    run_cmd(OP_READ, ADDR_STATUS, 8'hff, q);
    check({30'h0, q[1:0]}, {30'h0, l, r});
    check({30'h0, q[9:8]}, 32'h2);
    poll_is(8'h7f);
    run_cmd(OP_ACK_STATUS, ADDR_ACK, 8'hff, q);
    wait_req(1'b1);
    repeat (20) @(posedge ref_clk);
    req_is(1'b1);
  endtask

  task automatic t_status;
    logic [31:0] q;
    bus_cycle(1'b1, OFS_IRQ_MASK, 32'h2, q);
    status_round(1'b0, 1'b1);
    check({31'h0, irq}, 32'h1);
    bus_cycle(1'b1, OFS_IRQ_STATUS, 32'h2, q);
    repeat (3) @(posedge ref_clk);
    check({31'h0, irq}, 32'h0);
    status_round(1'b1, 1'b1);
    status_round(1'b1, 1'b0);
    status_round(1'b0, 1'b0);
  endtask

  task automatic t_sweep;
    logic [31:0] q;
    bus_cycle(1'b1, OFS_IRQ_MASK, 32'h0, q);
    pulse_end();
    req_is(1'b1);
    run_cmd(OP_WRITE, ADDR_TRIGGER, 8'h02, q);
    pulse_end();
    wait_req(1'b0);
    check({31'h0, irq}, 32'h0);
    poll_is(8'hef);
    lock_lost <= 1'b1;
    repeat (20) @(posedge ref_clk);
    poll_is(8'h6f);
    run_cmd(OP_ACK_SWEEP, ADDR_ACK, ACK_SWEEP_WORD, q);
    req_is(1'b0);
    poll_is(8'h7f);
    run_cmd(OP_READ, ADDR_STATUS, 8'hff, q);
    run_cmd(OP_ACK_STATUS, ADDR_ACK, 8'hff, q);
    wait_req(1'b1);
    run_cmd(OP_WRITE, ADDR_TRIGGER, 8'h00, q);
    pulse_end();
    req_is(1'b1);
  endtask

  initial begin
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_ref_select();
    t_status();
    t_sweep();
    test_done();
  end
endmodule

// >>> testbench/sweep_bus_assertions.sv
// Checker of the instrument bus between the two service-request ends.
// Assumes it sees the carrier's driven and resolved signals directly.
`timescale 1ns/1ps
module sweep_bus_assertions
  import sweep_bus_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [7:0] addr,
  input wire logic read_strobe,
  input wire logic write_strobe,
  input wire logic poll,
  input wire logic [7:0] dev_db_out,
  input wire logic [7:0] dev_db_oe_n,
  input wire logic service_request_n_out,
  input wire logic service_request_n_oe_n,
  input wire logic service_request_n
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  // Eight cycles leave room for the input filter of the device end.
  AST_STATUS_DRIVEN: assert property (
    (read_strobe && !poll && addr == ADDR_STATUS)[*8]
      |-> dev_db_oe_n[1:0] == 2'b00)
    else $error("status bits not driven in a status read");

  AST_NO_STRAY_DRIVE: assert property (
    (!poll && addr != ADDR_STATUS)[*8] |-> dev_db_oe_n == 8'hff)
    else $error("device drives data outside a status read");

  AST_POLL_ONLY_BITS: assert property (
    (poll && addr[POLL_ADDR_BIT])[*8]
      |-> (dev_db_oe_n | dev_db_out | 8'h90) == 8'hff)
    else $error("poll answer pulls a wrong data bit low");

  AST_POLL_MEANS_REQ: assert property (
    (poll && addr[POLL_ADDR_BIT])[*8] ##0
      !(dev_db_oe_n[POLL_SWEEP_BIT] && dev_db_oe_n[POLL_STATUS_BIT])
      |-> !service_request_n)
    else $error("poll answer given while request line released");

  AST_REQ_OPEN_DRAIN: assert property (
    !service_request_n_oe_n |-> !service_request_n_out)
    else $error("request line driven high");

  AST_POLL_ADDR: assert property (
    $rose(poll) && addr[POLL_ADDR_BIT] |-> addr == ADDR_POLL)
    else $error("poll raised with a wrong poll address");

  AST_ACK_ADDR: assert property (
    $rose(poll) && !addr[POLL_ADDR_BIT] |-> addr == ADDR_ACK)
    else $error("acknowledge pulse with a wrong address");

  AST_ADDR_STEADY: assert property (
    poll && $past(poll) |-> $stable(addr))
    else $error("address moved while poll high");

  AST_NO_STROBE_IN_POLL: assert property (
    poll |-> !read_strobe && !write_strobe)
    else $error("strobe active while poll high");
endmodule
